// >>> core/simd_state_pkg.sv
// Constants and types for the vector register and control/status block.
// Assumes one processor clock and an active-low asynchronous reset.
`default_nettype none
package simd_state_pkg;
    // -------------------------------------------------------------
    // Control/status field positions
    // -------------------------------------------------------------
    localparam int FLAG_LSB = 0;
    localparam int FLAG_W   = 6;
    localparam int DAZ_BIT  = 6;
    localparam int MASK_LSB = 7;
    localparam int RND_LSB  = 13;
    localparam int FTZ_BIT  = 15;
    localparam int RSV_LSB  = 16;
    localparam logic [31:0] CSR_RESET = 32'h0000_1f80;
    localparam logic [31:0] RSV_BITS  = 32'hffff_0000;
    localparam logic [31:0] DAZ_ONLY  = 32'h0000_0040;
    // -------------------------------------------------------------
    // Exception indices within the flag and mask groups
    // -------------------------------------------------------------
    localparam int EX_INV = 0;
    localparam int EX_DEN = 1;
    localparam int EX_DVZ = 2;
    localparam int EX_OVF = 3;
    localparam int EX_UNF = 4;
    localparam int EX_PRE = 5;
    // -------------------------------------------------------------
    // Access sizes and rounding modes
    // -------------------------------------------------------------
    typedef logic [1:0] acc_size_t;
    localparam acc_size_t ACC_32  = 2'h0;
    localparam acc_size_t ACC_64  = 2'h1;
    localparam acc_size_t ACC_128 = 2'h2;
    localparam logic [15:0] BEN_32  = 16'h000f;
    localparam logic [15:0] BEN_64  = 16'h00ff;
    localparam logic [15:0] BEN_128 = 16'hffff;
    typedef enum logic [1:0] {
        RND_NEAREST = 2'h0,
        RND_DOWN    = 2'h1,
        RND_UP      = 2'h2,
        RND_ZERO    = 2'h3
    } round_t;
endpackage
`default_nettype wire

// >>> core/simd_vector_regs.sv
// Vector data registers and floating-point control/status register.
// Assumes the execution pipeline presents at most one access per kind per cycle.
// Overview of operation
// - Eight 128-bit vector registers, index 0-7
// - Vector registers are private, unaliased storage
// - Load and store at 32/64/128 bits
// - Full store: low byte at lowest address
// - Control bits 16-31 reserved, read zero
// - Nonzero reserved bit write faults, no update
// - Flags 0-5 sticky until written zero
// - Bits 7-12 mask their exceptions
// - All masks set at reset
// - Loading unmasked set flag does not fault
// - Bits 13-14 select rounding mode
// - Masked underflow with flush gives signed zero
// - Flush ignored when underflow unmasked
// - Flush enable cleared at reset
// - Bit 6 zeroes denormal source operands
// - Zeroing suppresses denormal flag and fault
// - Zeroing enable cleared at reset
// - Without zeroing feature, bit 6 faults
// - Control word loaded/restored, stored/saved
// - 128-bit operands 16-byte aligned, exemptions
// - Four 32-bit singles per 128 bits
// - One state shared by all generations
`default_nettype none
module simd_vector_regs #(
    parameter int NUM_VREGS     = 8,
    parameter int VEC_W         = 128,
    parameter bit DAZ_SUPPORTED = 1'b1
) (
    input  wire logic                        clk_in,
    input  wire logic                        rst_n_in,
    input  wire logic                        vec_wr_en_in,
    input  wire logic [2:0]                  vec_wr_idx_in,
    input  wire simd_state_pkg::acc_size_t   vec_wr_size_in,
    input  wire logic                        vec_wr_high_in,
    input  wire logic [3:0]                  vec_wr_addr_in,
    input  wire logic                        vec_wr_unaligned_in,
    input  wire logic [127:0]                vec_wr_data_in,
    input  wire logic                        vec_rd_en_in,
    input  wire logic [2:0]                  vec_rd_idx_in,
    input  wire simd_state_pkg::acc_size_t   vec_rd_size_in,
    input  wire logic                        vec_rd_high_in,
    input  wire logic [3:0]                  vec_rd_addr_in,
    input  wire logic                        vec_rd_unaligned_in,
    input  wire logic                        csr_wr_en_in,
    input  wire logic [31:0]                 csr_wr_data_in,
    input  wire logic                        exc_valid_in,
    input  wire logic [5:0]                  exc_detect_in,
    input  wire logic                        op_valid_in,
    input  wire logic [127:0]                op_data_in,
    input  wire logic                        res_valid_in,
    input  wire logic [127:0]                res_data_in,
    input  wire logic [3:0]                  res_underflow_in,
    output logic [127:0]                     vec_rd_data_out,
    output logic [15:0]                      vec_rd_byte_en_out,
    output logic                             vec_rd_valid_out,
    output logic                             align_fault_out,
    output logic                             protection_fault_out,
    output logic [31:0]                      csr_out,
    output logic                             fp_fault_out,
    output logic [127:0]                     op_data_out,
    output logic [127:0]                     res_data_out
);
    import simd_state_pkg::*;

    // -------------------------------------------------------------
    // State
    // -------------------------------------------------------------
    typedef struct packed {
        logic [NUM_VREGS-1:0][VEC_W-1:0] vreg;
        logic [31:0]                     csr;
        logic [127:0]                    rd_data;
        logic [15:0]                     rd_ben;
        logic                            rd_valid;
        logic                            align_flt;
        logic                            prot_flt;
        logic                            fp_flt;
        logic [127:0]                    opnd;
        logic [127:0]                    res;
    } state_t;

    state_t      st_r;
    state_t      st_nxt;
    logic [31:0] rsv_mask;
    logic [3:0]  op_denorm;
    logic [127:0] op_zeroed;
    logic [127:0] res_flushed;
    logic        daz_on;
    logic        ftz_act;
    logic        wr_misal;
    logic        rd_misal;

    assign daz_on   = st_r.csr[DAZ_BIT];
    // Flush only when underflow masked
    assign ftz_act  = st_r.csr[FTZ_BIT] && st_r.csr[MASK_LSB+EX_UNF];
    assign rsv_mask = DAZ_SUPPORTED ? RSV_BITS : (RSV_BITS | DAZ_ONLY);

    // 128-bit accesses need 16-byte alignment unless flagged unaligned
    assign wr_misal = vec_wr_en_in && (vec_wr_size_in == ACC_128)
                      && (vec_wr_addr_in != 4'h0) && !vec_wr_unaligned_in;
    assign rd_misal = vec_rd_en_in && (vec_rd_size_in == ACC_128)
                      && (vec_rd_addr_in != 4'h0) && !vec_rd_unaligned_in;

    // -------------------------------------------------------------
    // Per-lane single precision handling
    // -------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            logic [31:0] o;
            logic [31:0] r;
            assign o = op_data_in[32*g +: 32];
            assign r = res_data_in[32*g +: 32];
            assign op_denorm[g] = (o[30:23] == 8'h00) && (o[22:0] != 23'h000000);
            assign op_zeroed[32*g +: 32] = (daz_on && op_denorm[g]) ?
                                           {o[31], 31'h00000000} : o;
            assign res_flushed[32*g +: 32] = (ftz_act && res_underflow_in[g]) ?
                                             {r[31], 31'h00000000} : r;
        end
    endgenerate

    // -------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------
    always_comb begin
        logic [5:0] ev;
        logic [5:0] msk;
        ev  = 6'h00;
        msk = st_r.csr[MASK_LSB +: FLAG_W];
        st_nxt = st_r;
        st_nxt.prot_flt  = 1'b0;
        st_nxt.align_flt = wr_misal || rd_misal;
        st_nxt.rd_valid  = 1'b0;
        st_nxt.fp_flt    = 1'b0;
        st_nxt.opnd      = op_zeroed;
        st_nxt.res       = res_flushed;

        // Vector load; only this port writes the vector file
        if (vec_wr_en_in && !wr_misal) begin
            case (vec_wr_size_in)
                ACC_32: begin
                    st_nxt.vreg[vec_wr_idx_in][31:0] = vec_wr_data_in[31:0];
                end
                ACC_64: begin
                    if (vec_wr_high_in) begin
                        st_nxt.vreg[vec_wr_idx_in][127:64] = vec_wr_data_in[63:0];
                    end else begin
                        st_nxt.vreg[vec_wr_idx_in][63:0] = vec_wr_data_in[63:0];
                    end
                end
                ACC_128: begin
                    st_nxt.vreg[vec_wr_idx_in] = vec_wr_data_in;
                end
                default: begin
                end
            endcase
        end

        // Vector store; byte k of data goes to address base+k
        if (vec_rd_en_in && !rd_misal) begin
            st_nxt.rd_valid = 1'b1;
            case (vec_rd_size_in)
                ACC_32: begin
                    st_nxt.rd_data = {96'h0, st_r.vreg[vec_rd_idx_in][31:0]};
                    st_nxt.rd_ben  = BEN_32;
                end
                ACC_64: begin
                    st_nxt.rd_data = {64'h0, vec_rd_high_in ?
                                      st_r.vreg[vec_rd_idx_in][127:64] :
                                      st_r.vreg[vec_rd_idx_in][63:0]};
                    st_nxt.rd_ben  = BEN_64;
                end
                ACC_128: begin
                    st_nxt.rd_data = st_r.vreg[vec_rd_idx_in];
                    st_nxt.rd_ben  = BEN_128;
                end
                default: begin
                    st_nxt.rd_valid = 1'b0;
                end
            endcase
        end

        // Control word load or restore
        if (csr_wr_en_in) begin
            if ((csr_wr_data_in & rsv_mask) != 32'h0) begin
                st_nxt.prot_flt = 1'b1;
            end else begin
                st_nxt.csr = csr_wr_data_in;
            end
        end

        // Detected conditions; flags set whether masked or not
        if (exc_valid_in) begin
            ev = exc_detect_in;
        end
        if (op_valid_in && (op_denorm != 4'h0)) begin
            ev[EX_DEN] = 1'b1;
        end
        if (daz_on) begin
            ev[EX_DEN] = 1'b0;
        end
        if (ftz_act && ev[EX_UNF]) begin
            ev[EX_PRE] = 1'b1;
        end
        // Set wins over a same-cycle clear
        st_nxt.csr[FLAG_LSB +: FLAG_W] = st_nxt.csr[FLAG_LSB +: FLAG_W] | ev;
        st_nxt.fp_flt = (ev & ~msk) != 6'h00;
    end

    // -------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r     <= '0;
            st_r.csr <= CSR_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign vec_rd_data_out      = st_r.rd_data;
    assign vec_rd_byte_en_out   = st_r.rd_ben;
    assign vec_rd_valid_out     = st_r.rd_valid;
    assign align_fault_out      = st_r.align_flt;
    assign protection_fault_out = st_r.prot_flt;
    assign csr_out              = st_r.csr;
    assign fp_fault_out         = st_r.fp_flt;
    assign op_data_out          = st_r.opnd;
    assign res_data_out         = st_r.res;

    // -------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    property p_rsv_zero;
        csr_out[31:RSV_LSB] == 16'h0000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero)
        else $error("reserved control bits nonzero");

    property p_gp_keep;
        (csr_wr_en_in && ((csr_wr_data_in[31:16] != 16'h0000)
         || (!DAZ_SUPPORTED && csr_wr_data_in[DAZ_BIT])))
            |=> protection_fault_out && (csr_out[31:6] == $past(csr_out[31:6]));
    endproperty
    a_gp_keep: assert property (p_gp_keep)
        else $error("reserved write did not fault or changed register");

    property p_sticky;
        !csr_wr_en_in |=> ((csr_out[5:0] & $past(csr_out[5:0])) == $past(csr_out[5:0]));
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("flag cleared without a load");

    property p_load_no_fault;
        (csr_wr_en_in && !exc_valid_in && !op_valid_in) |=> !fp_fault_out;
    endproperty
    a_load_no_fault: assert property (p_load_no_fault)
        else $error("control load raised a floating-point fault");

    property p_daz_no_de;
        (daz_on && !csr_wr_en_in && !csr_out[EX_DEN]
         && !(exc_valid_in && (exc_detect_in & 6'h3d) != 6'h00))
            |=> !csr_out[EX_DEN] && !fp_fault_out;
    endproperty
    a_daz_no_de: assert property (p_daz_no_de)
        else $error("denormal flag set while zeroing enabled");

    property p_ftz_flags;
        (ftz_act && exc_valid_in && exc_detect_in[EX_UNF])
            |=> csr_out[EX_UNF] && csr_out[EX_PRE];
    endproperty
    a_ftz_flags: assert property (p_ftz_flags)
        else $error("flush did not set underflow and precision");

    property p_unmasked_noflush;
        (!csr_out[MASK_LSB+EX_UNF] && res_valid_in) |=> res_data_out == $past(res_data_in);
    endproperty
    a_unmasked_noflush: assert property (p_unmasked_noflush)
        else $error("result flushed while underflow unmasked");

    property p_align;
        (vec_rd_en_in && vec_rd_size_in == ACC_128 && vec_rd_addr_in[0]
         && !vec_rd_unaligned_in) |=> align_fault_out && !vec_rd_valid_out;
    endproperty
    a_align: assert property (p_align)
        else $error("misaligned store not faulted");

    sequence s_full_load;
        vec_wr_en_in && vec_wr_size_in == ACC_128 && vec_wr_addr_in == 4'h0;
    endsequence
    sequence s_full_store;
        vec_rd_en_in && vec_rd_size_in == ACC_128 && vec_rd_addr_in == 4'h0
            && vec_rd_idx_in == $past(vec_wr_idx_in, 2) && !vec_wr_en_in;
    endsequence
    property p_roundtrip;
        s_full_load ##1 !vec_wr_en_in ##1 s_full_store
            |=> vec_rd_valid_out && vec_rd_data_out == $past(vec_wr_data_in, 3);
    endproperty
    a_roundtrip: assert property (p_roundtrip)
        else $error("full store did not return loaded data");

    property p_vec_private;
        !vec_wr_en_in |=> st_r.vreg == $past(st_r.vreg);
    endproperty
    a_vec_private: assert property (p_vec_private)
        else $error("vector register changed without a load");

    property p_store_32;
        (vec_rd_en_in && vec_rd_size_in == ACC_32)
            |=> vec_rd_valid_out && vec_rd_byte_en_out == BEN_32
                && vec_rd_data_out[127:32] == 96'h0;
    endproperty
    a_store_32: assert property (p_store_32)
        else $error("32-bit store shape wrong");

    property p_store_64;
        (vec_rd_en_in && vec_rd_size_in == ACC_64)
            |=> vec_rd_valid_out && vec_rd_byte_en_out == BEN_64
                && vec_rd_data_out[127:64] == 64'h0;
    endproperty
    a_store_64: assert property (p_store_64)
        else $error("64-bit store shape wrong");

    property p_store_128;
        (vec_rd_en_in && vec_rd_size_in == ACC_128
         && (vec_rd_addr_in == 4'h0 || vec_rd_unaligned_in))
            |=> vec_rd_valid_out && vec_rd_byte_en_out == BEN_128;
    endproperty
    a_store_128: assert property (p_store_128)
        else $error("full store shape wrong");

    property p_load_align;
        (vec_wr_en_in && vec_wr_size_in == ACC_128 && vec_wr_addr_in != 4'h0
         && !vec_wr_unaligned_in) |=> align_fault_out;
    endproperty
    a_load_align: assert property (p_load_align)
        else $error("misaligned load not faulted");

    property p_csr_load;
        (csr_wr_en_in && csr_wr_data_in[31:16] == 16'h0000
         && (DAZ_SUPPORTED || !csr_wr_data_in[DAZ_BIT]))
            |=> !protection_fault_out && csr_out[31:6] == $past(csr_wr_data_in[31:6]);
    endproperty
    a_csr_load: assert property (p_csr_load)
        else $error("control load did not take its value");

    property p_ctrl_hold;
        !csr_wr_en_in |=> csr_out[15:6] == $past(csr_out[15:6]);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control fields changed without a load");

    property p_unmasked_fault;
        (exc_valid_in && (exc_detect_in & ~csr_out[MASK_LSB +: FLAG_W] & 6'h3d) != 6'h00)
            |=> fp_fault_out;
    endproperty
    a_unmasked_fault: assert property (p_unmasked_fault)
        else $error("unmasked exception did not fault");

    property p_daz_lane;
        (daz_on && op_data_in[62:55] == 8'h00 && op_data_in[54:32] != 23'h000000)
            |=> op_data_out[62:32] == 31'h00000000
                && op_data_out[63] == $past(op_data_in[63]);
    endproperty
    a_daz_lane: assert property (p_daz_lane)
        else $error("denormal operand not zeroed");

    property p_ftz_lane;
        (ftz_act && res_underflow_in[0])
            |=> res_data_out[30:0] == 31'h00000000
                && res_data_out[31] == $past(res_data_in[31]);
    endproperty
    a_ftz_lane: assert property (p_ftz_lane)
        else $error("underflowing result not flushed");
endmodule
`default_nettype wire

// >>> sim/exec_pipe_model.sv
// Execution pipeline model: issues loads, stores, control writes and events.
// Assumes one rising-edge clock; tasks are called from one bench process.
`default_nettype none
module exec_pipe_model (
    input  wire logic                 clk_in,
    output logic                      vec_wr_en_in, vec_wr_high_in, vec_wr_unaligned_in,
    output logic                      vec_rd_en_in, vec_rd_high_in, vec_rd_unaligned_in,
    output logic [2:0]                vec_wr_idx_in, vec_rd_idx_in,
    output var simd_state_pkg::acc_size_t vec_wr_size_in, vec_rd_size_in,
    output logic [3:0]                vec_wr_addr_in, vec_rd_addr_in, res_underflow_in,
    output logic [127:0]              vec_wr_data_in, op_data_in, res_data_in,
    output logic                      csr_wr_en_in, exc_valid_in, op_valid_in, res_valid_in,
    output logic [31:0]               csr_wr_data_in,
    output logic [5:0]                exc_detect_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import simd_state_pkg::*;

    initial {vec_wr_en_in, vec_wr_high_in, vec_wr_unaligned_in, vec_rd_en_in,
             vec_rd_high_in, vec_rd_unaligned_in, vec_wr_idx_in, vec_rd_idx_in,
             vec_wr_size_in, vec_rd_size_in, vec_wr_addr_in, vec_rd_addr_in,
             res_underflow_in, vec_wr_data_in, op_data_in, res_data_in, csr_wr_en_in,
             exc_valid_in, op_valid_in, res_valid_in, csr_wr_data_in, exc_detect_in} = '0;

    // Released data lines show inverted garbage, not the last value
    task automatic vload(input logic [2:0] i, input acc_size_t s, input logic h,
                         input logic [3:0] a, input logic u, input logic [127:0] d);
        @(posedge clk_in);
        vec_wr_en_in        <= 1'b1;
        vec_wr_idx_in       <= i;
        vec_wr_size_in      <= s;
        vec_wr_high_in      <= h;
        vec_wr_addr_in      <= a;
        vec_wr_unaligned_in <= u;
        vec_wr_data_in      <= d;
        @(posedge clk_in);
        vec_wr_en_in        <= 1'b0;
        vec_wr_data_in      <= ~d;
    endtask

    task automatic vstore(input logic [2:0] i, input acc_size_t s, input logic h,
                          input logic [3:0] a, input logic u);
        @(posedge clk_in);
        vec_rd_en_in        <= 1'b1;
        vec_rd_idx_in       <= i;
        vec_rd_size_in      <= s;
        vec_rd_high_in      <= h;
        vec_rd_addr_in      <= a;
        vec_rd_unaligned_in <= u;
        @(posedge clk_in);
        vec_rd_en_in        <= 1'b0;
    endtask

    task automatic csrw(input logic [31:0] v);
        @(posedge clk_in);
        csr_wr_en_in   <= 1'b1;
        csr_wr_data_in <= v;
        @(posedge clk_in);
        csr_wr_en_in   <= 1'b0;
        csr_wr_data_in <= ~v;
    endtask

    task automatic ev(input logic [5:0] x, input logic ov, input logic [127:0] od,
                      input logic rv, input logic [127:0] rd, input logic [3:0] u);
        @(posedge clk_in);
        exc_valid_in     <= |x;
        exc_detect_in    <= x;
        op_valid_in      <= ov;
        op_data_in       <= od;
        res_valid_in     <= rv;
        res_data_in      <= rd;
        res_underflow_in <= u;
        @(posedge clk_in);
        exc_valid_in     <= 1'b0;
        op_valid_in      <= 1'b0;
        res_valid_in     <= 1'b0;
        op_data_in       <= ~od;
        res_data_in      <= ~rd;
    endtask
endmodule
`default_nettype wire

// >>> sim/tb_simd_vector_regs.sv
// Self-checking bench for the vector register and control/status block.
// Assumes the pipeline model in exec_pipe_model drives every design input except clock and reset, which the bench drives.
`default_nettype none
module tb_simd_vector_regs;
    timeunit 1ns;
    timeprecision 1ps;
    import simd_state_pkg::*;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic vec_wr_en_in, vec_wr_high_in, vec_wr_unaligned_in, csr_wr_en_in, exc_valid_in;
    logic vec_rd_en_in, vec_rd_high_in, vec_rd_unaligned_in, op_valid_in, res_valid_in;
    logic vec_rd_valid_out, align_fault_out, protection_fault_out, fp_fault_out;
    logic [2:0] vec_wr_idx_in, vec_rd_idx_in;
    acc_size_t vec_wr_size_in, vec_rd_size_in, s;
    logic [3:0] vec_wr_addr_in, vec_rd_addr_in, res_underflow_in;
    logic [127:0] vec_wr_data_in, op_data_in, res_data_in, vec_rd_data_out, op_data_out;
    logic [127:0] res_data_out, d;
    logic [127:0] exp_reg [8];
    logic [31:0] csr_wr_data_in, csr_out, c;
    logic [15:0] vec_rd_byte_en_out;
    logic [5:0] exc_detect_in;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    simd_vector_regs dut (.*);
    exec_pipe_model pipe (.*);

    always #10 clk_in = ~clk_in;

    // ----------------------------------------------------------------
    // Checking helpers
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [127:0] merge(input logic [127:0] o, input acc_size_t z,
                                           input logic h, input logic [127:0] v);
        logic [127:0] r;
        r = o;
        if (z == ACC_32) r[31:0] = v[31:0];
        else if (z == ACC_64 && h) r[127:64] = v[63:0];
        else if (z == ACC_64) r[63:0] = v[63:0];
        else if (z == ACC_128) r = v;
        return r;
    endfunction

    function automatic logic [127:0] view(input logic [127:0] r, input acc_size_t z,
                                          input logic h);
        if (z == ACC_32) return {96'h0, r[31:0]};
        if (z == ACC_64) return h ? {64'h0, r[127:64]} : {64'h0, r[63:0]};
        return r;
    endfunction

    task automatic st(input logic [2:0] i, input acc_size_t z, input logic h);
        pipe.vstore(i, z, h, (z == ACC_128) ? 4'h0 : 4'($urandom), 1'($urandom));
        #1;
        chk("store valid", 128'(vec_rd_valid_out), 128'h1);
        chk("store data", vec_rd_data_out, view(exp_reg[i], z, h));
        chk("byte enables", 128'(vec_rd_byte_en_out),
            (z == ACC_32) ? 128'h000f : (z == ACC_64) ? 128'h00ff : 128'hffff);
    endtask

    task automatic end_sim();
        if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'h420b));
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("csr reset", 128'(csr_out), 128'h1f80);
        for (int k = 0; k < 8; k++) begin
            d = {$urandom, $urandom, $urandom, $urandom};
            exp_reg[k] = d;
            pipe.vload(3'(k), ACC_128, 1'b0, 4'h0, 1'b0, d);
        end
        for (int k = 0; k < 8; k++) st(3'(k), ACC_128, 1'b0);
        for (int n = 0; n < 30; n++) begin
            d = {$urandom, $urandom, $urandom, $urandom};
            s = acc_size_t'($urandom_range(2));
            c = $urandom;
            exp_reg[c[2:0]] = merge(exp_reg[c[2:0]], s, c[3], d);
            pipe.vload(c[2:0], s, c[3], (s == ACC_128) ? 4'h0 : c[7:4], c[9], d);
            #1;
            chk("scalar no fault", 128'(align_fault_out), 128'h0);
            st(c[2:0], acc_size_t'($urandom_range(2)), c[8]);
        end
        pipe.vload(3'h5, ACC_128, 1'b0, 4'h4, 1'b0, ~exp_reg[5]);
        #1;
        chk("misaligned load", 128'(align_fault_out), 128'h1);
        st(3'h5, ACC_128, 1'b0);
        exp_reg[5] = d;
        pipe.vload(3'h5, ACC_128, 1'b0, 4'h4, 1'b1, d);
        #1;
        chk("unaligned move", 128'(align_fault_out), 128'h0);
        st(3'h5, ACC_128, 1'b0);
        pipe.vstore(3'h5, ACC_128, 1'b0, 4'h8, 1'b0);
        #1;
        chk("misaligned store", 128'({align_fault_out, vec_rd_valid_out}), 128'h2);
        pipe.csrw(32'h0001_1f80);
        #1;
        chk("reserved fault", 128'(protection_fault_out), 128'h1);
        chk("reserved kept", 128'(csr_out), 128'h1f80);
        for (int r = 0; r < 4; r++) begin
            pipe.csrw(32'h1f80 | 32'(r << 13));
            #1;
            chk("rounding field", 128'(csr_out), 128'(32'h1f80 | 32'(r << 13)));
        end
        pipe.csrw(32'h0000_1f80);
        for (int e = 0; e < 6; e++) begin
            pipe.ev(6'(1 << e), 1'b0, '0, 1'b0, '0, 4'h0);
            #1;
            chk("masked no fault", 128'(fp_fault_out), 128'h0);
            chk("sticky flags", 128'(csr_out), 128'(32'h1f80 | 32'((2 << e) - 1)));
        end
        pipe.csrw(32'h0000_1f80);
        #1;
        chk("flags cleared", 128'(csr_out), 128'h1f80);
        for (int e = 0; e < 6; e++) begin
            pipe.csrw((32'h1f80 & ~32'(1 << (7 + e))) | 32'(1 << e));
            #1;
            chk("load no fault", 128'(fp_fault_out), 128'h0);
            pipe.ev(6'(1 << e), 1'b0, '0, 1'b0, '0, 4'h0);
            #1;
            chk("unmasked fault", 128'(fp_fault_out), 128'h1);
        end
        pipe.csrw(32'h0000_1f80);
        d = {32'h3f80_0000, 32'h0000_0001, 32'h8000_0002, 32'h4000_0000};
        pipe.ev(6'h0, 1'b1, d, 1'b0, '0, 4'h0);
        #1;
        chk("operand kept", op_data_out, d);
        chk("denormal flag", 128'(csr_out), 128'h1f82);
        pipe.csrw(32'h0000_1ec0);
        pipe.ev(6'h02, 1'b1, d, 1'b0, '0, 4'h0);
        #1;
        chk("zeroed operand", op_data_out, {32'h3f80_0000, 64'h8000_0000, 32'h4000_0000});
        chk("den suppressed", 128'({fp_fault_out, csr_out}), 128'h1ec0);
        d = {32'h3f80_0000, 32'h4000_0000, 32'h1234_5678, 32'h8000_0123};
        pipe.csrw(32'h0000_9f80);
        pipe.ev(6'h10, 1'b0, '0, 1'b1, d, 4'h3);
        #1;
        chk("flushed result", res_data_out, {d[127:64], 64'h8000_0000});
        chk("flush flags", 128'(csr_out), 128'h9fb0);
        pipe.csrw(32'h0000_9780);
        pipe.ev(6'h0, 1'b0, '0, 1'b1, d, 4'h3);
        #1;
        chk("flush ignored", res_data_out, d);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("csr second reset", 128'(csr_out), 128'h1f80);
        exp_reg[2] = '0;
        st(3'h2, ACC_128, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
